//--- bench/vxc_host.sv
// Host configuration master model driving the register bank
`timescale 1ns/1ns
module vxc_host
  import vxc_pkg::*;
(
  input  wire logic         sys_clk,
  output vxc_cfg_req_t      cfg_req,
  input  wire vxc_cfg_rsp_t cfg_rsp
);
  initial cfg_req = '0;

  // ----------------------------------------------------------------
  // Single-word accesses, one request pulse each
  // ----------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    wr_be(a, d, 4'hf);
  endtask

  task automatic wr_be(input logic [11:0] a, input logic [31:0] d, input logic [3:0] b);
    @(posedge sys_clk);
    cfg_req.wr    <= 1'b1;
    cfg_req.addr  <= a;
    cfg_req.wdata <= d;
    cfg_req.be    <= b;
    @(posedge sys_clk);
    cfg_req.wr    <= 1'b0;
  endtask

  // Answer is awaited on falling edges so the registered reply has settled
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic ok);
    int n;
    ok = 1'b0;
    d  = 'x;
    @(posedge sys_clk);
    cfg_req.rd   <= 1'b1;
    cfg_req.addr <= a;
    @(posedge sys_clk);
    cfg_req.rd   <= 1'b0;
    for (n = 0; n < 4 && !ok; n++)
    begin
      @(negedge sys_clk);
      if (cfg_rsp.valid === 1'b1)
      begin
        ok = 1'b1;
        d  = cfg_rsp.rdata;
      end
    end
  endtask
endmodule

//--- bench/vxc_regs_tb.sv
// Self-checking testbench for the vendor extended capability register bank
`timescale 1ns/1ns
module vxc_regs_tb
  import vxc_pkg::*;
;
  localparam logic [11:0]  NXT = 12'h300;
  localparam logic [15:0]  SID = 16'h3c3c;  // Arbitrary value
  localparam logic [3:0]   SRV = 4'h2;
  localparam logic [31:0]  MRK = 32'h0123_4567;  // Arbitrary value
  localparam logic [127:0] SIL = 128'h0f1e_2d3c_4b5a_6978_8796_a5b4_c3d2_e1f0;  // Arbitrary value
  localparam logic [15:0]  BRD = 16'h0bd1;

  logic           sys_clk;
  logic           reset;
  vxc_cfg_req_t   cfg_req;
  vxc_cfg_rsp_t   cfg_rsp;
  vxc_link_stat_t link_stat;
  logic [31:0]    unc_ev;
  logic [31:0]    cor_ev;
  logic [31:0]    mode_ctrl;
  logic           unc_flag;
  logic           cor_flag;
  logic [31:0]    prog_ctrl;
  logic [31:0]    link_data;
  logic [31:0]    link_data_high;
  logic           link_data_wr;
  int             error_cnt;
  int             cmp_count;

  vxc_host i_host (.sys_clk(sys_clk), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp));

  vxc_regs #(.NEXT_CAP_OFFSET(NXT), .STRUCT_ID(SID), .STRUCT_REV(SRV), .MARKER_VALUE(MRK),
             .SILICON_ID(SIL), .BOARD_TYPE_ID(BRD)) i_dut (
    .sys_clk(sys_clk), .reset(reset), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
    .link_stat(link_stat), .unc_err_event(unc_ev), .cor_err_event(cor_ev),
    .mode_ctrl(mode_ctrl), .prog_ctrl(prog_ctrl), .link_data(link_data),
    .link_data_high(link_data_high), .link_data_wr(link_data_wr),
    .unc_err_flag(unc_flag), .cor_err_flag(cor_flag));

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // Reporting helpers
  // ----------------------------------------------------------------
  task automatic wrap_up();
    if (error_cnt == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask

  // A missing answer ends the run rather than hanging it
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic        ok;
    i_host.rd(a, d, ok);
    if (ok !== 1'b1)
    begin
      $display("BAD read_answer expected 1 seen 0");
      error_cnt++;
      wrap_up();
    end
    chk($sformatf("word_%h", a), exp, d);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_ident();
    int i;
    rchk(12'h200, {NXT, 4'h1, 16'h000b});
    rchk(12'h204, {12'h044, SRV, SID});
    rchk(12'h208, MRK);
    for (i = 0; i < 4; i++)
      rchk(12'h20c + 12'(4 * i), SIL[32 * i +: 32]);
    rchk(12'h21c, {6'h00, link_stat, 2'b00, BRD});
  endtask

  // Writes to read-only and reserved words must leave every value intact
  task automatic t_ro_writes();
    int i;
    for (i = 0; i < 8; i++)
      i_host.wr(12'h200 + 12'(4 * i), 32'hffff_ffff);
    i_host.wr(12'h230, 32'hffff_ffff);
    @(posedge sys_clk);
    link_stat <= 8'h5a;
    t_ident();
    rchk(12'h230, 32'h0000_0000);
  endtask

  // Programming registers: writable fields, byte enables and the data strobe
  task automatic t_link_regs();
    int n;
    i_host.wr(12'h220, 32'hffff_ffff);
    rchk(12'h220, 32'h0000_ff06);
    chk("mode_ctrl", 32'h0000_ff06, mode_ctrl);
    i_host.wr(12'h22c, 32'h1234_5678);
    rchk(12'h22c, 32'h1234_5678);
    chk("prog_ctrl", 32'h1234_5678, prog_ctrl);
    i_host.wr(12'h224, 32'hcafe_0001);
    i_host.wr_be(12'h224, 32'h0000_77ee, 4'h1);
    rchk(12'h224, 32'hcafe_00ee);
    chk("link_data_high", 32'hcafe_00ee, link_data_high);
    i_host.wr(12'h228, 32'h89ab_cdef);
    n = 0;
    repeat (4)
    begin
      @(negedge sys_clk);
      n += int'(link_data_wr);
    end
    chk("link_data_wr_pulses", 32'(1), 32'(n));
    chk("link_data", 32'h89ab_cdef, link_data);
    rchk(12'h228, 32'h89ab_cdef);
    rchk(12'h244, 32'h0000_0000);
  endtask

  // Sticky status, mask and write-one-to-clear for both error pairs
  task automatic t_errors();
    int          k;
    logic [11:0] b;
    for (k = 0; k < 2; k++)
    begin
      b = 12'h234 + 12'(8 * k);
      @(posedge sys_clk);
      if (k == 0) unc_ev <= 32'h0000_0008;
      else        cor_ev <= 32'h0000_0008;
      @(posedge sys_clk);
      unc_ev <= '0;
      cor_ev <= '0;
      rchk(b, 32'h0000_0008);
      chk("err_flag", 32'(1), 32'(k == 0 ? unc_flag : cor_flag));
      i_host.wr(b + 12'h004, 32'h0000_0008);
      rchk(b + 12'h004, 32'h0000_0008);
      chk("err_flag_masked", 32'(0), 32'(k == 0 ? unc_flag : cor_flag));
      i_host.wr(b, 32'h0000_0008);
      rchk(b, 32'h0000_0000);
      // An event in the cycle of a clear must survive it
      fork
        i_host.wr(b, 32'h0000_0008);
        begin
          @(posedge sys_clk);
          if (k == 0) unc_ev <= 32'h0000_0008;
          else        cor_ev <= 32'h0000_0008;
          @(posedge sys_clk);
          unc_ev <= '0;
          cor_ev <= '0;
        end
      join
      rchk(b, 32'h0000_0008);
      i_host.wr(b, 32'h0000_0008);
      rchk(b, 32'h0000_0000);
    end
  endtask

  initial
  begin
    error_cnt = 0;
    cmp_count = 0;
    reset     = 1'b1;
    link_stat = 8'ha5;
    unc_ev    = '0;
    cor_ev    = '0;
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    @(negedge sys_clk);
    chk("mode_ctrl_reset", 32'h0, mode_ctrl);
    chk("flags_reset", 32'h0, {30'h0, unc_flag, cor_flag});
    chk("link_reset", 32'h0, prog_ctrl | link_data | link_data_high);
    chk("link_data_wr_reset", 32'h0, 32'(link_data_wr));
    t_ident();
    t_ro_writes();
    t_link_regs();
    t_errors();
    wrap_up();
  end
endmodule

//--- hdl/vxc_pkg.sv
// Package for the vendor extended capability register bank
package vxc_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses in configuration space)
  // ----------------------------------------------------------------
  localparam logic [11:0] VXC_OFF_CAP_HDR     = 12'h200;
  localparam logic [11:0] VXC_OFF_VS_HDR      = 12'h204;
  localparam logic [11:0] VXC_OFF_MARKER      = 12'h208;
  localparam logic [11:0] VXC_OFF_SID0        = 12'h20c;
  localparam logic [11:0] VXC_OFF_SID1        = 12'h210;
  localparam logic [11:0] VXC_OFF_SID2        = 12'h214;
  localparam logic [11:0] VXC_OFF_SID3        = 12'h218;
  localparam logic [11:0] VXC_OFF_LINK_STAT   = 12'h21c;
  localparam logic [11:0] VXC_OFF_MODE_CTRL   = 12'h220;
  localparam logic [11:0] VXC_OFF_DATA_HIGH   = 12'h224;
  localparam logic [11:0] VXC_OFF_DATA        = 12'h228;
  localparam logic [11:0] VXC_OFF_PROG_CTRL   = 12'h22c;
  localparam logic [11:0] VXC_OFF_RESERVED    = 12'h230;
  localparam logic [11:0] VXC_OFF_UNC_STAT    = 12'h234;
  localparam logic [11:0] VXC_OFF_UNC_MASK    = 12'h238;
  localparam logic [11:0] VXC_OFF_COR_STAT    = 12'h23c;
  localparam logic [11:0] VXC_OFF_COR_MASK    = 12'h240;

  // ----------------------------------------------------------------
  // Fixed field values
  // ----------------------------------------------------------------
  localparam logic [15:0] VXC_EXT_CAP_ID      = 16'h000b;
  localparam logic [3:0]  VXC_CAP_VERSION     = 4'h1;
  localparam logic [11:0] VXC_STRUCT_LENGTH   = 12'h044;

  // Field positions of the status word at 0x21c
  localparam int          VXC_STAT_LSB        = 18;
  localparam int          VXC_STAT_W          = 8;

  // Reset values
  localparam logic [31:0] VXC_RST_WORD        = 32'h0000_0000;
  localparam logic [7:0]  VXC_RST_NUMCLKS     = 8'h00;

  // ----------------------------------------------------------------
  // Configuration access carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [3:0]  be;
  } vxc_cfg_req_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] rdata;
  } vxc_cfg_rsp_t;

  // Status mirrored from the configuration-over-link controller
  typedef struct packed {
    logic core_ready;
    logic clk_in_use;
    logic config_done;
    logic spare;
    logic user_mode;
    logic enabled;
    logic config_error;
    logic config_ready;
  } vxc_link_stat_t;

  // Writable control/error state
  typedef struct packed {
    logic [31:0] mode_ctrl;
    logic [31:0] data_high;
    logic [31:0] data;
    logic [31:0] prog_ctrl;
    logic [31:0] unc_stat;
    logic [31:0] unc_mask;
    logic [31:0] cor_stat;
    logic [31:0] cor_mask;
  } vxc_ctl_t;

  typedef struct packed {
    vxc_ctl_t     ctl;
    vxc_cfg_rsp_t rsp;
    logic         data_wr;
  } vxc_state_t;

endpackage

//--- hdl/vxc_regs.sv
// Vendor extended capability register bank in configuration space
`timescale 1ns/1ns
// Behaviour
// - Capability header bits 15:0 return fixed ID 0x000b, read-only.
// - Capability header bits 19:16 return version one, read-only.
// - Capability header bits 31:20 return next capability offset or zero.
// - Vendor header ID and revision are instantiation parameters; writes ignored.
// - Vendor header holds user structure ID 15:0 and revision 19:16.
// - Vendor header bits 31:20 report structure length 0x044.
// - Read-only 32-bit marker word with device-defined value.
// - 128-bit silicon identifier as four read-only words, lowest first.
// - 16-bit read-only board type identifier set at configuration.
// - Internal error status and mask pairs occupy 0x234 through 0x240.
// - Bits 25:18 of board-type word mirror link configuration status.
module vxc_regs
  import vxc_pkg::*;
#(
  parameter logic [11:0]  NEXT_CAP_OFFSET = 12'h000,
  parameter logic [15:0]  STRUCT_ID       = 16'h1172,  // Arbitrary value
  parameter logic [3:0]   STRUCT_REV      = 4'h0,
  parameter logic [31:0]  MARKER_VALUE    = 32'h5a5a_0001,  // Arbitrary value
  parameter logic [127:0] SILICON_ID      = 128'h0,  // Arbitrary value
  parameter logic [15:0]  BOARD_TYPE_ID   = 16'h0000
)(
  input  wire logic           sys_clk,
  input  wire logic           reset,
  input  wire vxc_cfg_req_t   cfg_req,
  output vxc_cfg_rsp_t        cfg_rsp,
  input  wire vxc_link_stat_t link_stat,
  input  wire logic [31:0]    unc_err_event,
  input  wire logic [31:0]    cor_err_event,
  output logic [31:0]         mode_ctrl,
  output logic [31:0]         prog_ctrl,
  output logic [31:0]         link_data,
  output logic [31:0]         link_data_high,
  output logic                link_data_wr,
  output logic                unc_err_flag,
  output logic                cor_err_flag
);

  // ----------------------------------------------------------------
  // Read-only words
  // ----------------------------------------------------------------
  logic [31:0] cap_hdr;
  logic [31:0] vs_hdr;
  logic [31:0] stat_word;

  assign cap_hdr   = {NEXT_CAP_OFFSET, VXC_CAP_VERSION, VXC_EXT_CAP_ID};
  assign vs_hdr    = {VXC_STRUCT_LENGTH, STRUCT_REV, STRUCT_ID};
  // Status sits at 25:18, the rest of the upper half reads zero
  assign stat_word = {6'h00, link_stat, 2'h0, BOARD_TYPE_ID};

  // ----------------------------------------------------------------
  // Byte-enable write merge
  // ----------------------------------------------------------------
  function automatic logic [31:0] vxc_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Write-one-to-clear on error status, with a new event winning over the clear
  function automatic logic [31:0] vxc_w1c(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be,
                                          input logic        hit,
                                          input logic [31:0] ev);
    logic [31:0] clr;
    clr = hit ? (wd & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}}) : 32'h0000_0000;
    return (old & ~clr) | ev;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  vxc_state_t st;
  vxc_state_t next_st;
  logic       wr_hit;

  assign wr_hit = cfg_req.wr;

  always_comb
  begin
    next_st           = st;
    next_st.rsp.valid = 1'b0;
    next_st.data_wr   = 1'b0;

    // Hardware events set status every cycle
    next_st.ctl.unc_stat = vxc_w1c(st.ctl.unc_stat, cfg_req.wdata, cfg_req.be,
                                   wr_hit && cfg_req.addr == VXC_OFF_UNC_STAT,
                                   unc_err_event);
    next_st.ctl.cor_stat = vxc_w1c(st.ctl.cor_stat, cfg_req.wdata, cfg_req.be,
                                   wr_hit && cfg_req.addr == VXC_OFF_COR_STAT,
                                   cor_err_event);

    if (wr_hit)
    begin
      // Header, marker, identifier and reserved words ignore writes
      case (cfg_req.addr)
        VXC_OFF_MODE_CTRL:
        begin
          // Only the clock count and the two control bits are writable
          next_st.ctl.mode_ctrl = vxc_merge(st.ctl.mode_ctrl, cfg_req.wdata, cfg_req.be)
                                  & 32'h0000_ff06;
        end
        VXC_OFF_DATA_HIGH:
        begin
          next_st.ctl.data_high = vxc_merge(st.ctl.data_high, cfg_req.wdata, cfg_req.be);
        end
        VXC_OFF_DATA:
        begin
          next_st.ctl.data = vxc_merge(st.ctl.data, cfg_req.wdata, cfg_req.be);
          next_st.data_wr = 1'b1;
        end
        VXC_OFF_PROG_CTRL:
        begin
          next_st.ctl.prog_ctrl = vxc_merge(st.ctl.prog_ctrl, cfg_req.wdata, cfg_req.be);
        end
        VXC_OFF_UNC_MASK:
        begin
          next_st.ctl.unc_mask = vxc_merge(st.ctl.unc_mask, cfg_req.wdata, cfg_req.be);
        end
        VXC_OFF_COR_MASK:
        begin
          next_st.ctl.cor_mask = vxc_merge(st.ctl.cor_mask, cfg_req.wdata, cfg_req.be);
        end
        default:
        begin
          next_st.ctl = next_st.ctl;
        end
      endcase
    end

    if (cfg_req.rd)
    begin
      next_st.rsp.valid = 1'b1;
      case (cfg_req.addr)
        VXC_OFF_CAP_HDR:   next_st.rsp.rdata = cap_hdr;
        VXC_OFF_VS_HDR:    next_st.rsp.rdata = vs_hdr;
        VXC_OFF_MARKER:    next_st.rsp.rdata = MARKER_VALUE;
        VXC_OFF_SID0:      next_st.rsp.rdata = SILICON_ID[31:0];
        VXC_OFF_SID1:      next_st.rsp.rdata = SILICON_ID[63:32];
        VXC_OFF_SID2:      next_st.rsp.rdata = SILICON_ID[95:64];
        VXC_OFF_SID3:      next_st.rsp.rdata = SILICON_ID[127:96];
        VXC_OFF_LINK_STAT: next_st.rsp.rdata = stat_word;
        VXC_OFF_MODE_CTRL: next_st.rsp.rdata = st.ctl.mode_ctrl;
        VXC_OFF_DATA_HIGH: next_st.rsp.rdata = st.ctl.data_high;
        VXC_OFF_DATA:      next_st.rsp.rdata = st.ctl.data;
        VXC_OFF_PROG_CTRL: next_st.rsp.rdata = st.ctl.prog_ctrl;
        VXC_OFF_UNC_STAT:  next_st.rsp.rdata = st.ctl.unc_stat;
        VXC_OFF_UNC_MASK:  next_st.rsp.rdata = st.ctl.unc_mask;
        VXC_OFF_COR_STAT:  next_st.rsp.rdata = st.ctl.cor_stat;
        VXC_OFF_COR_MASK:  next_st.rsp.rdata = st.ctl.cor_mask;
        default:           next_st.rsp.rdata = VXC_RST_WORD;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic unc_flag_q;
  logic cor_flag_q;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      unc_flag_q <= 1'b0;
      cor_flag_q <= 1'b0;
    end
    else
    begin
      unc_flag_q <= |(next_st.ctl.unc_stat & ~next_st.ctl.unc_mask);
      cor_flag_q <= |(next_st.ctl.cor_stat & ~next_st.ctl.cor_mask);
    end
  end

  assign cfg_rsp        = st.rsp;
  assign mode_ctrl      = st.ctl.mode_ctrl;
  assign prog_ctrl      = st.ctl.prog_ctrl;
  assign link_data      = st.ctl.data;
  assign link_data_high = st.ctl.data_high;
  assign link_data_wr   = st.data_wr;
  assign unc_err_flag   = unc_flag_q;
  assign cor_err_flag   = cor_flag_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_CAP_ID: assert property (@(posedge sys_clk) disable iff (reset)
    cfg_req.rd && cfg_req.addr == VXC_OFF_CAP_HDR |=> cfg_rsp.valid && cfg_rsp.rdata[15:0] == 16'h000b)
    else $error("Capability ID wrong");
  AST_CAP_VER: assert property (@(posedge sys_clk) disable iff (reset)
    cfg_req.rd && cfg_req.addr == VXC_OFF_CAP_HDR |=> cfg_rsp.rdata[19:16] == 4'h1)
    else $error("Capability version wrong");
  AST_CAP_NEXT: assert property (@(posedge sys_clk) disable iff (reset)
    cfg_req.rd && cfg_req.addr == VXC_OFF_CAP_HDR |=> cfg_rsp.rdata[31:20] == NEXT_CAP_OFFSET)
    else $error("Next offset wrong");
  AST_VS_HDR: assert property (@(posedge sys_clk) disable iff (reset)
    cfg_req.rd && cfg_req.addr == VXC_OFF_VS_HDR |=> cfg_rsp.rdata[19:0] == {STRUCT_REV, STRUCT_ID})
    else $error("Vendor header wrong");
  AST_VS_LEN: assert property (@(posedge sys_clk) disable iff (reset)
    cfg_req.rd && cfg_req.addr == VXC_OFF_VS_HDR |=> cfg_rsp.rdata[31:20] == 12'h044)
    else $error("Structure length wrong");
  AST_MARKER: assert property (@(posedge sys_clk) disable iff (reset)
    cfg_req.rd && cfg_req.addr == VXC_OFF_MARKER |=> cfg_rsp.rdata == MARKER_VALUE)
    else $error("Marker wrong");
  AST_SID0: assert property (@(posedge sys_clk) disable iff (reset)
    cfg_req.rd && cfg_req.addr == VXC_OFF_SID0 |=> cfg_rsp.rdata == SILICON_ID[31:0])
    else $error("Silicon id word 0 wrong");
  AST_SID1: assert property (@(posedge sys_clk) disable iff (reset)
    cfg_req.rd && cfg_req.addr == VXC_OFF_SID1 |=> cfg_rsp.rdata == SILICON_ID[63:32])
    else $error("Silicon id word 1 wrong");
  AST_SID2: assert property (@(posedge sys_clk) disable iff (reset)
    cfg_req.rd && cfg_req.addr == VXC_OFF_SID2 |=> cfg_rsp.rdata == SILICON_ID[95:64])
    else $error("Silicon id word 2 wrong");
  AST_SID3: assert property (@(posedge sys_clk) disable iff (reset)
    cfg_req.rd && cfg_req.addr == VXC_OFF_SID3 |=> cfg_rsp.rdata == SILICON_ID[127:96])
    else $error("Silicon id high word wrong");
  AST_STAT: assert property (@(posedge sys_clk) disable iff (reset)
    cfg_req.rd && cfg_req.addr == VXC_OFF_LINK_STAT
    |=> cfg_rsp.rdata == {6'h00, $past(link_stat), 2'h0, BOARD_TYPE_ID})
    else $error("Status word wrong");
  AST_BOARD_ID: assert property (@(posedge sys_clk) disable iff (reset)
    cfg_req.rd && cfg_req.addr == VXC_OFF_LINK_STAT |=> cfg_rsp.rdata[15:0] == BOARD_TYPE_ID)
    else $error("Board type id wrong");
  AST_UNC_STICKY: assert property (@(posedge sys_clk) disable iff (reset)
    |unc_err_event |=> (st.ctl.unc_stat & $past(unc_err_event)) == $past(unc_err_event))
    else $error("Error event lost");
  AST_COR_STICKY: assert property (@(posedge sys_clk) disable iff (reset)
    |cor_err_event |=> (st.ctl.cor_stat & $past(cor_err_event)) == $past(cor_err_event))
    else $error("Correctable error event lost");
  AST_UNC_HOLD: assert property (@(posedge sys_clk) disable iff (reset)
    !(cfg_req.wr && cfg_req.addr == VXC_OFF_UNC_STAT)
    |=> (st.ctl.unc_stat & $past(st.ctl.unc_stat)) == $past(st.ctl.unc_stat))
    else $error("Uncorrectable status bit lost without a clear");
  AST_COR_HOLD: assert property (@(posedge sys_clk) disable iff (reset)
    !(cfg_req.wr && cfg_req.addr == VXC_OFF_COR_STAT)
    |=> (st.ctl.cor_stat & $past(st.ctl.cor_stat)) == $past(st.ctl.cor_stat))
    else $error("Correctable status bit lost without a clear");
  AST_UNC_FLAG: assert property (@(posedge sys_clk) disable iff (reset)
    |(unc_err_event & ~st.ctl.unc_mask) && !(cfg_req.wr && cfg_req.addr == VXC_OFF_UNC_MASK)
    |=> unc_err_flag)
    else $error("Unmasked uncorrectable error not flagged");
  AST_COR_FLAG: assert property (@(posedge sys_clk) disable iff (reset)
    |(cor_err_event & ~st.ctl.cor_mask) && !(cfg_req.wr && cfg_req.addr == VXC_OFF_COR_MASK)
    |=> cor_err_flag)
    else $error("Unmasked correctable error not flagged");
  AST_RSVD: assert property (@(posedge sys_clk) disable iff (reset)
    cfg_req.rd && cfg_req.addr == VXC_OFF_RESERVED |=> cfg_rsp.rdata == 32'h0000_0000)
    else $error("Reserved word not zero");

  // ----------------------------------------------------------------
  // Write side and reply timing
  // ----------------------------------------------------------------
  AST_RSVD_WR: assert property (@(posedge sys_clk) disable iff (reset)
    cfg_req.wr && cfg_req.addr == VXC_OFF_RESERVED
    |=> $stable({mode_ctrl, prog_ctrl, link_data, link_data_high, st.ctl.unc_mask, st.ctl.cor_mask}))
    else $error("Write to reserved word changed state");
  AST_RO_WR: assert property (@(posedge sys_clk) disable iff (reset)
    cfg_req.wr && cfg_req.addr <= VXC_OFF_LINK_STAT
    |=> $stable({mode_ctrl, prog_ctrl, link_data, link_data_high, st.ctl.unc_mask, st.ctl.cor_mask}))
    else $error("Write to read-only word changed state");
  AST_DATA_WR: assert property (@(posedge sys_clk) disable iff (reset)
    cfg_req.wr && cfg_req.addr == VXC_OFF_DATA |=> link_data_wr)
    else $error("Data strobe missing");
  AST_NO_DATA_WR: assert property (@(posedge sys_clk) disable iff (reset)
    !(cfg_req.wr && cfg_req.addr == VXC_OFF_DATA) |=> !link_data_wr)
    else $error("Data strobe without a data write");
  AST_RD_VALID: assert property (@(posedge sys_clk) disable iff (reset)
    cfg_req.rd |=> cfg_rsp.valid)
    else $error("Read not answered");
  AST_NO_RD_VALID: assert property (@(posedge sys_clk) disable iff (reset)
    !cfg_req.rd |=> !cfg_rsp.valid && $stable(cfg_rsp.rdata))
    else $error("Reply moved without a read");

  COV_DATA_WR: cover property (@(posedge sys_clk) disable iff (reset) link_data_wr);
  COV_UNC: cover property (@(posedge sys_clk) disable iff (reset) unc_err_flag);
  COV_MODE: cover property (@(posedge sys_clk) disable iff (reset) mode_ctrl[2]);
  COV_COR: cover property (@(posedge sys_clk) disable iff (reset) cor_err_flag);
  COV_SET_CLR: cover property (@(posedge sys_clk) disable iff (reset)
    |unc_err_event && cfg_req.wr && cfg_req.addr == VXC_OFF_UNC_STAT);

endmodule
